//--- rom_model.sv
// Behavioural serial configuration EEPROM that answers sequential reads.
`timescale 1ns/1ps

module rom_model
(
    input  wire logic i_select,
    input  wire logic i_sck,
    input  wire logic i_din,
    output logic      o_dout
);
    int          idx;
    logic [8:0]  cmd;
    logic [15:0] word;

    initial
    begin
        idx = 0;
        cmd = '0;
        word = '0;
        o_dout = 1'b0;
    end

    // Either edge of select restarts the bit count and drives the data pin low.
    always @(posedge i_select or negedge i_select)
    begin
        idx = 0;
        o_dout <= 1'b0;
    end

    // The data word echoes opcode and address, so a wrong command shows.
    always @(posedge i_sck)
    begin
        if (i_select)
        begin
            if (idx < 9)
                cmd = {cmd[7:0], i_din};
            if (idx == 9)
                word = {1'b1, cmd[8:6], 6'h2A, cmd[5:0]};
            if (idx >= 9 && idx < 25)
                o_dout <= word[24-idx];
            idx = idx + 1;
        end
    end
endmodule // rom_model

//--- serial_rom_config_loader.sv
// Serial EEPROM configuration loader with its word FIFO and register port.
`timescale 1ns/1ps
`include "serial_rom_config_loader_defs.svh"

module word_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    input  wire logic             i_clock,
    input  wire logic             i_arst_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW:0]                 wptr;
        logic [PW:0]                 rptr;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t next_s;
    logic        full;
    logic        empty;

    assign full        = (s.wptr[PW] != s.rptr[PW])
                       && (s.wptr[PW-1:0] == s.rptr[PW-1:0]);
    assign empty       = (s.wptr == s.rptr);
    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = s.mem[s.rptr[PW-1:0]];

    always_comb
    begin
        next_s = s;
        if (i_in_valid && !full)
        begin
            next_s.mem[s.wptr[PW-1:0]] = i_in_data;
            next_s.wptr = s.wptr + 1'b1;
        end
        if (i_out_ready && !empty)
        begin
            next_s.rptr = s.rptr + 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end
endmodule // word_fifo

// Function
// - Load only while the enable strap is high; a word already started still clocks out and is pushed.
// - Chip select frames every EEPROM access.
// - Serial clock 4us slow, 800ns at fast speed.
// - Command and address bits go out serially.
// - Configuration data sampled from serial input.
// - Serial input ignored when no EEPROM fitted.
// - Clock pin strap latched as endianness first.
module serial_rom_config_loader
    import serial_rom_config_loader_pkg::*;
#(
    parameter logic [6:0] WORDS = 7'h08,
    parameter int         DEPTH = 8
)
(
    input  wire logic                             i_clock,
    input  wire logic                             i_arst_n,
    input  wire logic [7:0]                       i_addr,
    input  wire logic [15:0]                      i_wdata,
    input  wire logic                             i_wr,
    input  wire logic                             i_rd,
    output logic [15:0]                           o_rdata,
    input  wire logic                             i_rom_load_strap,
    input  wire logic                             i_serial_rom_data_in,
    input  wire logic                             i_serial_rom_clock,
    output serial_rom_config_loader_pkg::rom_pins_t o_pins,
    output logic                                  o_big_endian
);
    import serial_rom_config_loader_pkg::*;

    loader_state_t s;
    loader_state_t next_s;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic          fifo_pop;
    logic [15:0]   fifo_out_data;
    logic          strap;
    logic          start_ok;

    // Half a serial clock period, minus one, for the chosen bus speed.
    function automatic logic [8:0] half_count(input logic [1:0] speed);
        if (speed == `SPEED_FAST)
        begin
            return 9'(`SCK_FAST_HALF - 1);
        end
        return 9'(`SCK_SLOW_HALF - 1);
    endfunction

    assign strap    = s.strap_sync[1];
    assign fifo_pop = i_rd && (i_addr == `REG_DATA);
    // A word starts only when the FIFO can take it, so a full FIFO
    // stalls the load between words instead of dropping data.
    assign start_ok = fifo_in_ready && !s.push;

    assign o_rdata      = s.rdata;
    assign o_pins       = s.pins;
    assign o_big_endian = s.big_endian;

    word_fifo #(
        .WIDTH (`WORD_BITS),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_clock     (i_clock),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (s.push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (s.rx),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_out_data)
    );

    always_comb
    begin
        next_s = s;
        next_s.push = 1'b0;
        next_s.sck_sync   = {s.sck_sync[0], i_serial_rom_clock};
        next_s.din_sync   = {s.din_sync[0], i_serial_rom_data_in};
        next_s.strap_sync = {s.strap_sync[0], i_rom_load_strap};

        if (i_wr && (i_addr == `REG_CTRL))
        begin
            next_s.speed = i_wdata[`CTRL_SPEED_LSB +: 2];
        end

        next_s.rdata = 16'h0000;
        if (i_rd)
        begin
            unique case (i_addr)
                `REG_CTRL:
                begin
                    next_s.rdata[`CTRL_SPEED_LSB +: 2] = s.speed;
                end
                `REG_STATUS:
                begin
                    next_s.rdata[`STAT_BUSY_BIT]  = s.busy;
                    next_s.rdata[`STAT_DONE_BIT]  = s.done;
                    next_s.rdata[`STAT_STRAP_BIT] = strap;
                    next_s.rdata[`STAT_BIG_BIT]   = s.big_endian;
                    next_s.rdata[`STAT_AVAIL_BIT] = fifo_out_valid;
                end
                `REG_DATA:
                begin
                    next_s.rdata = fifo_out_valid ? fifo_out_data
                                                  : 16'h0000;
                end
                default:
                begin
                    next_s.rdata = 16'h0000;
                end
            endcase
        end

        unique case (s.st)
            ST_STRAP:
            begin
                // The pin is not driven yet; the pulled level settles
                // through the synchroniser before it is taken.
                if (s.cnt == `STRAP_WAIT)
                begin
                    next_s.big_endian   = s.sck_sync[1];
                    next_s.endian_taken = 1'b1;
                    next_s.pins.serial_rom_clock_oe = 1'b1;
                    next_s.cnt = 9'h000;
                    next_s.st  = ST_IDLE;
                    next_s.busy = strap;
                end
                else
                begin
                    next_s.cnt = s.cnt + 9'h001;
                end
            end
            ST_IDLE:
            begin
                next_s.pins.eeprom_chip_select = 1'b0;
                next_s.pins.serial_rom_clock   = 1'b0;
                if (i_wr && (i_addr == `REG_CTRL)
                    && i_wdata[`CTRL_RELOAD_BIT] && strap)
                begin
                    next_s.busy = 1'b1;
                end
                if (s.busy && strap && start_ok)
                begin
                    next_s.done  = 1'b0;
                    next_s.waddr = 6'h00;
                    next_s.st    = ST_GAP;
                end
                else if (s.busy && !strap)
                begin
                    next_s.busy = 1'b0;
                end
            end
            ST_GAP:
            begin
                if (!strap)
                begin
                    next_s.busy = 1'b0;
                    next_s.st   = ST_IDLE;
                end
                else if (start_ok)
                begin
                    next_s.pins.eeprom_chip_select = 1'b1;
                    next_s.tx   = {`READ_OPCODE, s.waddr};
                    next_s.pins.serial_rom_data_out =
                        1'(`READ_OPCODE >> 2);
                    next_s.bitn = 5'h00;
                    next_s.cnt  = half_count(s.speed);
                    next_s.st   = ST_LOW;
                end
            end
            ST_LOW:
            begin
                if (s.cnt == 9'h000)
                begin
                    next_s.pins.serial_rom_clock = 1'b1;
                    next_s.cnt = half_count(s.speed);
                    next_s.st  = ST_HIGH;
                end
                else
                begin
                    next_s.cnt = s.cnt - 9'h001;
                end
            end
            ST_HIGH:
            begin
                if (s.cnt == 9'h000)
                begin
                    next_s.pins.serial_rom_clock = 1'b0;
                    next_s.bitn = s.bitn + 5'h01;
                    next_s.cnt  = half_count(s.speed);
                    if (s.bitn >= 5'(`CMD_BITS) && strap)
                    begin
                        next_s.rx = {s.rx[14:0], s.din_sync[1]};
                    end
                    next_s.tx = {s.tx[7:0], 1'b0};
                    next_s.pins.serial_rom_data_out = s.tx[7];
                    if (s.bitn == 5'(`CMD_BITS + `WORD_BITS - 1))
                    begin
                        next_s.pins.eeprom_chip_select  = 1'b0;
                        next_s.pins.serial_rom_data_out = 1'b0;
                        next_s.push  = 1'b1;
                        next_s.waddr = s.waddr + 6'h01;
                        if ({1'b0, s.waddr} == WORDS - 7'h01)
                        begin
                            next_s.busy = 1'b0;
                            next_s.done = 1'b1;
                            next_s.st   = ST_IDLE;
                        end
                        else
                        begin
                            next_s.st = ST_GAP;
                        end
                    end
                    else
                    begin
                        next_s.st = ST_LOW;
                    end
                end
                else
                begin
                    next_s.cnt = s.cnt - 9'h001;
                end
            end
            default:
            begin
                next_s.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            s       <= '0;
            s.speed <= `CTRL_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Helper: length of the current clock-high phase.
    logic [8:0] high_len;

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            high_len <= 9'h000;
        end
        else
        begin
            high_len <= s.pins.serial_rom_clock ? high_len + 9'h001
                                                : 9'h000;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_arst_n);

    AST_LOAD_NEEDS_STRAP:
        assert property ($rose(s.pins.eeprom_chip_select) |-> strap)
        else $error("Load started without the enable strap.");

    AST_CLOCK_INSIDE_SELECT:
        assert property (s.pins.serial_rom_clock
                         |-> s.pins.eeprom_chip_select)
        else $error("Serial clock high outside chip select.");

    AST_HALF_PERIOD:
        assert property ($fell(s.pins.serial_rom_clock)
            |-> high_len == (($past(s.speed) == `SPEED_FAST)
                             ? 9'(`SCK_FAST_HALF) : 9'(`SCK_SLOW_HALF)))
        else $error("Serial clock high phase has the wrong length.");

    AST_DATA_OUT_STABLE:
        assert property (s.pins.serial_rom_clock
                         && $past(s.pins.serial_rom_clock)
                         |-> $stable(s.pins.serial_rom_data_out))
        else $error("Data out changed while clock high.");

    AST_PUSH_AFTER_WORD:
        assert property (s.push |-> $past(s.bitn) == 5'h18 && strap)
        else $error("Word pushed at the wrong bit.");

    AST_INPUT_IGNORED:
        assert property (!strap && !$past(strap) |-> $stable(s.rx))
        else $error("Serial input sampled with no EEPROM fitted.");

    AST_ENDIAN_FIRST:
        assert property (s.pins.serial_rom_clock_oe |-> s.endian_taken)
        else $error("Clock pin driven before endian strap taken.");

    AST_IDLE_PINS:
        assert property (s.st == ST_IDLE |=> !s.pins.eeprom_chip_select
                         && !s.pins.serial_rom_clock)
        else $error("Select or clock active while idle.");
endmodule // serial_rom_config_loader

//--- serial_rom_config_loader_defs.svh
// Offsets, field positions, reset values and timing counts of the loader.
`ifndef SERIAL_ROM_CONFIG_LOADER_DEFS_SVH
`define SERIAL_ROM_CONFIG_LOADER_DEFS_SVH

`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_DATA        8'h08

`define CTRL_SPEED_LSB  0
`define CTRL_RELOAD_BIT 8
`define CTRL_RESET      2'h3

`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1
`define STAT_STRAP_BIT  2
`define STAT_BIG_BIT    3
`define STAT_AVAIL_BIT  4

`define SPEED_FAST      2'h0
`define CLK_NS          10
`define SCK_SLOW_NS     4000
`define SCK_FAST_NS     800
`define SCK_SLOW_HALF   ((`SCK_SLOW_NS) / (2 * `CLK_NS))
`define SCK_FAST_HALF   ((`SCK_FAST_NS) / (2 * `CLK_NS))
`define STRAP_WAIT      9'h004

`define ADDR_BITS       6
`define CMD_BITS        9
`define WORD_BITS       16
`define READ_OPCODE     3'h6

`endif

//--- serial_rom_config_loader_pkg.sv
// Types shared by the serial configuration loader.
package serial_rom_config_loader_pkg;

    typedef enum logic [2:0] {
        ST_STRAP = 3'b000,
        ST_IDLE  = 3'b001,
        ST_LOW   = 3'b010,
        ST_HIGH  = 3'b011,
        ST_GAP   = 3'b100
    } load_state_t;

    typedef struct packed {
        logic eeprom_chip_select;
        logic serial_rom_clock;
        logic serial_rom_clock_oe;
        logic serial_rom_data_out;
    } rom_pins_t;

    typedef struct packed {
        load_state_t st;
        logic [8:0]  cnt;
        logic [4:0]  bitn;
        logic [8:0]  tx;
        logic [15:0] rx;
        logic [5:0]  waddr;
        logic [1:0]  sck_sync;
        logic [1:0]  din_sync;
        logic [1:0]  strap_sync;
        logic        big_endian;
        logic        endian_taken;
        logic [1:0]  speed;
        logic        busy;
        logic        done;
        logic        push;
        rom_pins_t   pins;
        logic [15:0] rdata;
    } loader_state_t;

endpackage

//--- serial_rom_config_loader_test.sv
// Self-checking testbench of the serial configuration loader.
`timescale 1ns/1ps

module serial_rom_config_loader_test;
    import serial_rom_config_loader_pkg::*;

    logic        clock;
    logic        arst_n;
    logic        wr;
    logic        rd;
    logic        strap;
    logic        pull;
    logic        din;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] seen;
    logic        big;
    rom_pins_t   pins;
    wire logic   sck_pin;
    int          n_errors;
    int          n_tests;
    realtime     t0;

    // The clock pin carries the strap pull until the loader drives it.
    assign sck_pin = pins.serial_rom_clock_oe ? pins.serial_rom_clock : pull;

    serial_rom_config_loader
    #(
        .WORDS (7'h03),
        .DEPTH (2)
    )
    u_serial_rom_config_loader
    (
        .i_clock              (clock),
        .i_arst_n             (arst_n),
        .i_addr               (addr),
        .i_wdata              (wdata),
        .i_wr                 (wr),
        .i_rd                 (rd),
        .o_rdata              (rdata),
        .i_rom_load_strap     (strap),
        .i_serial_rom_data_in (din),
        .i_serial_rom_clock   (sck_pin),
        .o_pins               (pins),
        .o_big_endian         (big)
    );

    rom_model u_rom_model
    (
        .i_select (pins.eeprom_chip_select),
        .i_sck    (pins.serial_rom_clock),
        .i_din    (pins.serial_rom_data_out),
        .o_dout   (din)
    );

    initial
    begin
        clock = 1'b0;
        forever
            #5 clock = ~clock;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic do_reset(input logic s, input logic p);
        @(posedge clock);
        arst_n <= 1'b0;
        strap <= s;
        pull <= p;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 seen = rdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        rd_reg(a);
        check(seen, exp);
    endtask

    task automatic period(input logic [15:0] exp_ns);
        @(posedge pins.serial_rom_clock);
        t0 = $realtime;
        @(posedge pins.serial_rom_clock);
        check(16'(int'($realtime - t0)), exp_ns);
    endtask

    // Polling stays bounded; the status check after it catches a load that never ends.
    task automatic wait_done();
        for (int i = 0; i < 400; i++)
        begin
            rd_reg(8'h04);
            if (seen[1] === 1'b1)
                break;
            repeat (50) @(posedge clock);
        end
    endtask

    initial
    begin
        arst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        strap = 1'b0;
        pull = 1'b1;
        n_errors = 0;
        n_tests = 0;
        do_reset(1'b0, 1'b1);
        check(16'(pins.serial_rom_clock_oe), 16'h0000);
        repeat (20) @(posedge clock);
        check(16'(big), 16'h0001);
        check(16'(pins.serial_rom_clock_oe), 16'h0001);
        wr_reg(8'h00, 16'h0100);
        repeat (300) @(posedge clock);
        check(16'(pins.eeprom_chip_select), 16'h0000);
        check(16'(pins.serial_rom_clock), 16'h0000);
        rdc(8'h04, 16'h0008);
        rdc(8'h08, 16'h0000);
        @(posedge clock);
        strap <= 1'b1;
        repeat (5) @(posedge clock);
        wr_reg(8'h00, 16'h0000);
        wr_reg(8'h00, 16'h0100);
        period(16'd800);
        check(16'(pins.eeprom_chip_select), 16'h0001);
        // Two words fill the FIFO; the third must wait with select low.
        repeat (7000) @(posedge clock);
        check(16'(pins.eeprom_chip_select), 16'h0000);
        rdc(8'h04, 16'h001D);
        rdc(8'h08, 16'hEA80);
        rdc(8'h08, 16'hEA81);
        wait_done();
        rdc(8'h04, 16'h001E);
        rdc(8'h08, 16'hEA82);
        rdc(8'h08, 16'h0000);
        rdc(8'h0C, 16'h0000);
        check(16'(pins.eeprom_chip_select), 16'h0000);
        check(16'(pins.serial_rom_clock), 16'h0000);
        do_reset(1'b1, 1'b0);
        repeat (20) @(posedge clock);
        check(16'(big), 16'h0000);
        rdc(8'h00, 16'h0003);
        period(16'd4000);
        check(16'(pins.eeprom_chip_select), 16'h0001);
        print_verdict();
    end

    initial
    begin
        #400000;
        n_errors++;
        print_verdict();
    end
endmodule // serial_rom_config_loader_test
